/* File: core/drs_pkg.sv */
/*
 drs_pkg: constants and types for the reference selector of the two loops.
 Assumes an 8-bit register port and eight monitored input clocks numbered 1-6, 8 and 9.
*/
package drs_pkg;

   // ==========================================
   // sizes
   localparam int NUM_IN = 8;
   localparam int AW = 4;
   localparam int DW = 8;

   // ==========================================
   // register offsets
   localparam logic [3:0] ADR_RANK0 = 4'h0;
   localparam logic [3:0] ADR_RANK1 = 4'h1;
   localparam logic [3:0] ADR_RANK2 = 4'h2;
   localparam logic [3:0] ADR_RANK3 = 4'h3;
   localparam logic [3:0] ADR_CTRL = 4'h4;
   localparam logic [3:0] ADR_MAIN_FORCE = 4'h5;
   localparam logic [3:0] ADR_AUX_FORCE = 4'h6;
   localparam logic [3:0] ADR_TAB_A = 4'h7;
   localparam logic [3:0] ADR_TAB_B = 4'h8;
   localparam logic [3:0] ADR_VALID = 4'h9;
   localparam logic [3:0] ADR_LATCH1 = 4'hA;
   localparam logic [3:0] ADR_LATCH2 = 4'hB;
   localparam logic [3:0] ADR_IEN1 = 4'hC;
   localparam logic [3:0] ADR_IEN2 = 4'hD;
   localparam logic [3:0] ADR_TOL = 4'hE;

   // ==========================================
   // control and latch register fields
   localparam int CTRL_VIEW = 0;
   localparam int CTRL_REVERTIVE_SWITCH_EN = 1;
   localparam int CTRL_ULTRA_FAST_SWITCH_EN = 2;
   localparam int CTRL_EXT_SWITCH_MODE_EN = 3;
   localparam int CTRL_PHMEAS = 4;
   localparam int LATCH2_FAIL = 0;

   // ==========================================
   // reset values; slot order 7..0 is input 9,8,6,5,4,3,2,1
   localparam logic [31:0] PRIO_MAIN_RST = 32'h5400_3210;
   localparam logic [31:0] PRIO_AUX_RST = 32'h0500_3210;
   localparam logic [31:0] IN_NUMBER = 32'h9865_4321;
   localparam logic [3:0] PRIO_OFF = 4'h0;
   localparam logic [3:0] FORCE_AUTO_LO = 4'h0;
   localparam logic [3:0] FORCE_AUTO_HI = 4'hF;
   localparam logic [3:0] NO_REF = 4'h0;

   // ==========================================
   // slots used by the external switch mode
   localparam logic [2:0] SLOT_IN3 = 3'h2;
   localparam logic [2:0] SLOT_IN4 = 3'h3;
   localparam logic [2:0] SLOT_IN5 = 3'h4;
   localparam logic [2:0] SLOT_IN6 = 3'h5;

   // ==========================================
   // types
   typedef struct packed {
      logic [2:0][2:0] idx;
      logic [2:0] vld;
   } drs_tab_s;

   typedef struct packed {
      logic vld;
      logic [2:0] idx;
   } drs_sel_s;

endpackage

/* File: core/drs_ref_selector.sv */
/*
 drs_ref_selector: priority ranking and reference selection for the main and aux loops,
 with force on both loops, and revertive control, ultra-fast switching and external switch mode on the main loop only.
 Assumes valid flags and the fast-monitor failure event are synchronous to mclk_i,
 and software accesses registers over a plain strobe port with read data one cycle later.
*/
`timescale 1ns/1ps

module drs_ref_selector
   import drs_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register port
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DW-1:0] rd_data_o,
   // monitors and pins
   input wire logic [NUM_IN-1:0] valid_i,
   input wire logic fast_fail_i,
   input wire logic ext_switch_pin_i,
   // selection results
   output logic [3:0] main_sel_o,
   output logic [3:0] aux_sel_o,
   output logic [NUM_IN-1:0] bucket_force_o,
   output logic prelock2_o,
   output logic freq_tol_wide_o,
   output logic interrupt_request_pin_o
);

   // ==========================================
   // helpers
   function automatic logic [3:0] drs_num(input logic [2:0] idx);
      drs_num = IN_NUMBER[idx*4 +: 4];
   endfunction

   // force code to slot; mode 0 auto, 1 forced, 2 nothing selected
   function automatic logic [4:0] drs_force(input logic [3:0] code);
      logic [4:0] r;
      r = 5'h00;
      if (code == FORCE_AUTO_LO || code == FORCE_AUTO_HI) begin
         r = 5'h00;
      end else begin
         r = 5'h10;
         for (int i = 0; i < NUM_IN; i++) begin
            if (IN_NUMBER[i*4 +: 4] == code) begin
               r = {2'b01, 3'(i)};
            end
         end
      end
      drs_force = r;
   endfunction

   // lowest {priority, circular distance from current} wins; current leads its tie
   // distance from the current slot makes ties nonrevertive without extra state;
   // the cost is three unrolled passes over all inputs in one cycle
   function automatic drs_tab_s drs_rank(input logic [31:0] pr, input logic [7:0] ok,
                                         input logic [2:0] base);
      drs_tab_s t;
      logic [7:0] left;
      logic [6:0] best;
      logic [6:0] key;
      logic [2:0] bi;
      logic bv;
      t = '0;
      left = ok;
      for (int n = 0; n < 3; n++) begin
         best = 7'h7F;
         bi = 3'h0;
         bv = 1'b0;
         for (int i = 0; i < NUM_IN; i++) begin
            key = {pr[i*4 +: 4], 3'(3'(i) - base)};
            if (left[i] && (!bv || key < best)) begin
               best = key;
               bi = 3'(i);
               bv = 1'b1;
            end
         end
         if (bv) begin
            left[bi] = 1'b0;
         end
         t.idx[n] = bi;
         t.vld[n] = bv;
      end
      drs_rank = t;
   endfunction

   // forced input on top, normal order pushed down one place
   function automatic drs_tab_s drs_table(input logic [31:0] pr, input logic [7:0] ok,
                                          input logic [2:0] base, input logic [4:0] frc);
      drs_tab_s n;
      drs_tab_s t;
      logic [7:0] m;
      m = ok;
      if (frc[4:3] == 2'b01) begin
         m[frc[2:0]] = 1'b0;
      end
      n = drs_rank(pr, m, base);
      t = n;
      if (frc[4:3] == 2'b01) begin
         t.idx = {n.idx[1], n.idx[0], frc[2:0]};
         t.vld = {n.vld[1], n.vld[0], 1'b1};
      end
      drs_table = t;
   endfunction

   // first usable table entry, or keep the current reference
   // a forced input that is invalid is skipped here, so the loop never locks
   // to a dead clock through the force field; external mode is the only way
   function automatic drs_sel_s drs_pick(input drs_tab_s t, input logic [7:0] ok,
                                         input drs_sel_s cur, input logic rev,
                                         input logic [4:0] frc);
      drs_sel_s s;
      s = cur;
      if (frc[4] == 1'b1) begin
         s = '0;
      end else if (rev || !(cur.vld && ok[cur.idx])) begin
         s = '0;
         for (int n = 2; n >= 0; n--) begin
            if (t.vld[n] && ok[t.idx[n]]) begin
               s = {1'b1, t.idx[n]};
            end
         end
      end
      drs_pick = s;
   endfunction

   // ==========================================
   // state
   logic [31:0] prio_main;
   logic [31:0] prio_aux;
   logic [4:0] ctrl;
   logic [3:0] main_force_sel;
   logic [3:0] aux_force_sel;
   logic [NUM_IN-1:0] ien1;
   logic ien2;
   logic [NUM_IN-1:0] latched;
   logic fail_flag;
   logic [NUM_IN-1:0] valid_q;
   logic [NUM_IN-1:0] ufs_kill;
   drs_sel_s main_sel;
   drs_sel_s aux_sel;
   logic [15:0] tab_main_q;
   logic [15:0] tab_aux_q;

   // ==========================================
   // combinational selection
   logic [NUM_IN-1:0] nz_main;
   logic [NUM_IN-1:0] nz_aux;
   logic [NUM_IN-1:0] ok_main;
   logic [NUM_IN-1:0] ok_aux;
   logic [4:0] frc_main;
   logic [4:0] frc_aux;
   drs_tab_s tab_main;
   drs_tab_s tab_aux;
   drs_sel_s next_main_sel;
   drs_sel_s next_aux_sel;
   drs_sel_s ext_sel;
   logic ufs_evt;
   logic [NUM_IN-1:0] rise_higher;

   genvar g;
   generate
      for (g = 0; g < NUM_IN; g++) begin : g_in
         assign nz_main[g] = prio_main[g*4 +: 4] != PRIO_OFF;
         assign nz_aux[g] = prio_aux[g*4 +: 4] != PRIO_OFF;
         assign rise_higher[g] = valid_i[g] && !valid_q[g] && nz_main[g] &&
            (!main_sel.vld || prio_main[g*4 +: 4] < prio_main[main_sel.idx*4 +: 4]);
      end
   endgenerate

   assign ok_main = valid_i & nz_main & ~ufs_kill;
   assign ok_aux = valid_i & nz_aux;
   assign frc_main = drs_force(main_force_sel);
   assign frc_aux = drs_force(aux_force_sel);
   assign tab_main = drs_table(prio_main, ok_main, main_sel.idx, frc_main);
   assign tab_aux = drs_table(prio_aux, ok_aux, aux_sel.idx, frc_aux);
   assign ufs_evt = ctrl[CTRL_ULTRA_FAST_SWITCH_EN] && fast_fail_i && main_sel.vld;

   // switch pin picks input 3 or 4 if its priority is nonzero, else input 5 or 6, validity ignored
   // the pin is used as is; a bouncing pin toggles the reference each cycle
   assign ext_sel = ext_switch_pin_i ?
      {1'b1, (nz_main[SLOT_IN3] ? SLOT_IN3 : SLOT_IN5)} :
      {1'b1, (nz_main[SLOT_IN4] ? SLOT_IN4 : SLOT_IN6)};

   always_comb begin
      next_main_sel = drs_pick(tab_main, ok_main, main_sel, ctrl[CTRL_REVERTIVE_SWITCH_EN], frc_main);
      if (ctrl[CTRL_EXT_SWITCH_MODE_EN]) begin
         next_main_sel = ext_sel;
      end
   end

   assign next_aux_sel = drs_pick(tab_aux, ok_aux, aux_sel, 1'b1, frc_aux);

   // ==========================================
   // priority registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prio_main <= PRIO_MAIN_RST;
         prio_aux <= PRIO_AUX_RST;
      end else if (ce_i && wr_i && addr_i <= ADR_RANK3) begin
         if (ctrl[CTRL_VIEW]) begin
            prio_aux[addr_i[1:0]*8 +: 8] <= wr_data_i;
         end else begin
            prio_main[addr_i[1:0]*8 +: 8] <= wr_data_i;
         end
      end
   end

   // ==========================================
   // control registers; external mode and tolerance caught from the pin in reset
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl <= 5'h00;
         ctrl[CTRL_EXT_SWITCH_MODE_EN] <= ext_switch_pin_i;
         freq_tol_wide_o <= ext_switch_pin_i;
         main_force_sel <= FORCE_AUTO_LO;
         aux_force_sel <= FORCE_AUTO_LO;
         ien1 <= 8'h00;
         ien2 <= 1'b0;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            ADR_CTRL: ctrl <= wr_data_i[4:0];
            ADR_MAIN_FORCE: main_force_sel <= wr_data_i[3:0];
            ADR_AUX_FORCE: aux_force_sel <= wr_data_i[3:0];
            ADR_IEN1: ien1 <= wr_data_i;
            ADR_IEN2: ien2 <= wr_data_i[LATCH2_FAIL];
            ADR_TOL: freq_tol_wide_o <= wr_data_i[0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // selection and table registers, updated every cycle with ce_i high
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         main_sel <= '0;
         aux_sel <= '0;
         main_sel_o <= NO_REF;
         aux_sel_o <= NO_REF;
         tab_main_q <= 16'h0000;
         tab_aux_q <= 16'h0000;
      end else if (ce_i) begin
         main_sel <= next_main_sel;
         aux_sel <= next_aux_sel;
         main_sel_o <= next_main_sel.vld ? drs_num(next_main_sel.idx) : NO_REF;
         aux_sel_o <= next_aux_sel.vld ? drs_num(next_aux_sel.idx) : NO_REF;
         // fields: third, second, top, selected
         tab_main_q <= {tab_main.vld[2] ? drs_num(tab_main.idx[2]) : NO_REF,
                        tab_main.vld[1] ? drs_num(tab_main.idx[1]) : NO_REF,
                        tab_main.vld[0] ? drs_num(tab_main.idx[0]) : NO_REF,
                        next_main_sel.vld ? drs_num(next_main_sel.idx) : NO_REF};
         tab_aux_q <= {tab_aux.vld[2] ? drs_num(tab_aux.idx[2]) : NO_REF,
                       tab_aux.vld[1] ? drs_num(tab_aux.idx[1]) : NO_REF,
                       tab_aux.vld[0] ? drs_num(tab_aux.idx[0]) : NO_REF,
                       next_aux_sel.vld ? drs_num(next_aux_sel.idx) : NO_REF};
      end
   end

   // ==========================================
   // ultra-fast switching; the kill lasts until the monitor drops the valid flag,
   // so the failed input cannot be picked again before its bucket catches up
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ufs_kill <= 8'h00;
         bucket_force_o <= 8'h00;
         prelock2_o <= 1'b0;
      end else if (ce_i) begin
         bucket_force_o <= 8'h00;
         prelock2_o <= ufs_evt;
         ufs_kill <= ufs_kill & valid_i;
         if (ufs_evt) begin
            bucket_force_o[main_sel.idx] <= 1'b1;
            ufs_kill[main_sel.idx] <= 1'b1;
         end
      end
   end

   // ==========================================
   // latched status, write one to clear; a new event beats a clear
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         valid_q <= 8'h00;
         latched <= 8'h00;
         fail_flag <= 1'b0;
         interrupt_request_pin_o <= 1'b0;
      end else if (ce_i) begin
         valid_q <= valid_i;
         latched <= (latched & ~((wr_i && addr_i == ADR_LATCH1) ? wr_data_i : 8'h00))
                    | rise_higher;
         fail_flag <= (fail_flag && !(wr_i && addr_i == ADR_LATCH2 && wr_data_i[LATCH2_FAIL]))
                      || fast_fail_i;
         interrupt_request_pin_o <= |(latched & ien1) || (fail_flag && ien2);
      end
   end

   // ==========================================
   // register reads, data valid only in the cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rd_data_o <= 8'h00;
      end else if (ce_i) begin
         rd_data_o <= 8'h00;
         if (rd_i) begin
            case (addr_i)
               ADR_RANK0, ADR_RANK1, ADR_RANK2, ADR_RANK3:
                  rd_data_o <= ctrl[CTRL_VIEW] ? prio_aux[addr_i[1:0]*8 +: 8] :
                                                 prio_main[addr_i[1:0]*8 +: 8];
               ADR_CTRL: rd_data_o <= {3'h0, ctrl};
               ADR_MAIN_FORCE: rd_data_o <= {4'h0, main_force_sel};
               ADR_AUX_FORCE: rd_data_o <= {4'h0, aux_force_sel};
               ADR_TAB_A: rd_data_o <= ctrl[CTRL_VIEW] ? tab_aux_q[7:0] : tab_main_q[7:0];
               ADR_TAB_B: rd_data_o <= ctrl[CTRL_VIEW] ? tab_aux_q[15:8] : tab_main_q[15:8];
               ADR_VALID: rd_data_o <= valid_i;
               ADR_LATCH1: rd_data_o <= latched;
               ADR_LATCH2: rd_data_o <= {7'h00, fail_flag};
               ADR_IEN1: rd_data_o <= ien1;
               ADR_IEN2: rd_data_o <= {7'h00, ien2};
               ADR_TOL: rd_data_o <= {7'h00, freq_tol_wide_o};
               default: rd_data_o <= 8'h00;
            endcase
         end
      end
   end

endmodule

/* File: tb/drs_ref_selector_sva.sv */
/* drs_ref_selector_sva: port checks of the reference selector.
 Assumes one clock, synchronous reset, mode bits written over the strobe port, external mode also caught from the pin in reset. */
`timescale 1ns/1ps
module drs_ref_selector_chk
   import drs_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register port
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DW-1:0] rd_data_o,
   // monitors, pins, results
   input wire logic [NUM_IN-1:0] valid_i,
   input wire logic fast_fail_i,
   input wire logic ext_switch_pin_i,
   input wire logic [3:0] main_sel_o,
   input wire logic [3:0] aux_sel_o,
   input wire logic [NUM_IN-1:0] bucket_force_o,
   input wire logic prelock2_o,
   input wire logic freq_tol_wide_o,
   input wire logic interrupt_request_pin_o
);
   // ====
   // shadow of mode bits; the control register itself is not visible here
   logic ext_q;
   logic ufs_q;
   logic [NUM_IN-1:0] vld_q;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ext_q <= ext_switch_pin_i;
         ufs_q <= 1'b0;
      end else if (ce_i && wr_i && addr_i == ADR_CTRL) begin
         ext_q <= wr_data_i[CTRL_EXT_SWITCH_MODE_EN];
         ufs_q <= wr_data_i[CTRL_ULTRA_FAST_SWITCH_EN];
      end
   end
   always_ff @(posedge mclk_i) begin
      vld_q <= valid_i;
   end
   function automatic logic [2:0] slot_of(input logic [3:0] n);
      return (n > 4'h6) ? 3'(n - 4'h2) : 3'(n - 4'h1);
   endfunction
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ====
   // assertions
   sequence ufs_fire;
      ce_i && fast_fail_i && ufs_q && !ext_q && main_sel_o != NO_REF;
   endsequence
   sequence ufs_pulse;
      prelock2_o && bucket_force_o == (8'h01 << slot_of($past(main_sel_o)));
   endsequence
   rd_idle_a: assert property ($past(ce_i) && !$past(rd_i) |-> rd_data_o == 8'h00)
      else $error("read data not zero outside a read");
   main_valid_a: assert property (!$past(rst_i) && $past(ce_i) && !$past(ext_q)
      && main_sel_o != NO_REF |-> vld_q[slot_of(main_sel_o)])
      else $error("main loop selected an invalid input");
   aux_valid_a: assert property (!$past(rst_i) && $past(ce_i) && aux_sel_o != NO_REF
      |-> vld_q[slot_of(aux_sel_o)])
      else $error("aux loop selected an invalid input");
   sel_legal_a: assert property (main_sel_o != 4'h7 && main_sel_o <= 4'h9
      && aux_sel_o != 4'h7 && aux_sel_o <= 4'h9)
      else $error("selection outside the input numbers");
   ext_pick_a: assert property (!$past(rst_i) && $past(ce_i) && $past(ext_q) |->
      ($past(ext_switch_pin_i) ? main_sel_o inside {4'h3, 4'h5} : main_sel_o inside {4'h4, 4'h6}))
      else $error("external switch picked the wrong input");
   tol_reset_a: assert property ($fell(rst_i) |-> freq_tol_wide_o == $past(ext_switch_pin_i))
      else $error("tolerance default not taken from the pin");
   ufs_step_a: assert property (ufs_fire |=> ufs_pulse ##1 main_sel_o != $past(main_sel_o, 2))
      else $error("ultra fast switch did not act");
   pulse_cause_a: assert property (prelock2_o || bucket_force_o != '0 |->
      $past(fast_fail_i) && $past(ufs_q) && prelock2_o && $onehot(bucket_force_o))
      else $error("switch pulses without a failure event");
endmodule

bind drs_ref_selector drs_ref_selector_chk i_drs_ref_selector_chk (
   .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
   .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .valid_i(valid_i),
   .fast_fail_i(fast_fail_i), .ext_switch_pin_i(ext_switch_pin_i), .main_sel_o(main_sel_o),
   .aux_sel_o(aux_sel_o), .bucket_force_o(bucket_force_o), .prelock2_o(prelock2_o),
   .freq_tol_wide_o(freq_tol_wide_o), .interrupt_request_pin_o(interrupt_request_pin_o));

/* File: tb/drs_src_model.sv */
/* drs_src_model: the reference clocks and their monitors as the selector sees them.
 Assumes the bench says which sources run and when one skips cycles. */
`timescale 1ns/1ps
module drs_src_model
   import drs_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // bench commands
   input wire logic [NUM_IN-1:0] run_i,
   input wire logic gap_i,
   // monitor results
   output logic [NUM_IN-1:0] valid_o,
   output logic fast_fail_o
);
   logic gap_q;
   // ====
   // flags lag the sources by a cycle; one event per gap, however long
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         valid_o <= '0;
         gap_q <= 1'b0;
         fast_fail_o <= 1'b0;
      end else begin
         valid_o <= run_i;
         gap_q <= gap_i;
         fast_fail_o <= gap_i && !gap_q;
      end
   end
endmodule

/* File: tb/tb_top.sv */
/* tb_top: register-level tests of the reference selector.
 Assumes read data one cycle after the strobe and selections one cycle after a change. */
`timescale 1ns/1ps
module tb_top
   import drs_pkg::*;
;
   logic mclk_i, rst_i, ce_i, wr_i, rd_i, fast_fail_i, ext_switch_pin_i, gap;
   logic [AW-1:0] addr_i;
   logic [DW-1:0] wr_data_i, rd_data_o;
   logic [NUM_IN-1:0] valid_i, run, bucket_force_o;
   logic [3:0] main_sel_o, aux_sel_o, exp_sel;
   logic prelock2_o, freq_tol_wide_o, interrupt_request_pin_o;
   logic [7:0] rank_main [4] = '{8'h10, 8'h32, 8'h00, 8'h54};
   logic [7:0] rank_aux [4] = '{8'h10, 8'h32, 8'h00, 8'h05};
   int fail_count, tests_run;
   drs_ref_selector i_drs_ref_selector (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
      .valid_i(valid_i), .fast_fail_i(fast_fail_i), .ext_switch_pin_i(ext_switch_pin_i),
      .main_sel_o(main_sel_o), .aux_sel_o(aux_sel_o), .bucket_force_o(bucket_force_o),
      .prelock2_o(prelock2_o), .freq_tol_wide_o(freq_tol_wide_o),
      .interrupt_request_pin_o(interrupt_request_pin_o));
   drs_src_model i_drs_src_model (.mclk_i(mclk_i), .rst_i(rst_i), .run_i(run), .gap_i(gap),
      .valid_o(valid_i), .fast_fail_o(fast_fail_i));
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // ====
   // access tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk(what, exp, rd_data_o);
   endtask
   task automatic run_to(input logic [7:0] v);
      @(posedge mclk_i);
      run <= v;
      cyc(3);
   endtask
   task automatic pin_to(input logic p);
      @(posedge mclk_i);
      ext_switch_pin_i <= p;
      cyc(2);
   endtask
   task automatic cm(input logic [3:0] e);
      chk("main sel", {4'h0, e}, {4'h0, main_sel_o});
   endtask
   task automatic ca(input logic [3:0] e);
      chk("aux sel", {4'h0, e}, {4'h0, aux_sel_o});
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic print_verdict();
      $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ====
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (6000) @(posedge mclk_i);
      fail_count++;
      $display("MISMATCH watchdog expected finish seen hang");
      print_verdict();
   end
   // ====
   // tests
   initial begin
      {rst_i, ce_i, wr_i, rd_i, ext_switch_pin_i, gap} = 6'b110000;
      addr_i = 4'h0;
      wr_data_i = 8'h00;
      run = 8'h00;
      fail_count = 0;
      tests_run = 0;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      cyc(2);
      chk("tol wide", 8'h00, {7'h0, freq_tol_wide_o});
      for (int i = 0; i < 4; i++) rd(4'(i), rank_main[i], "rank main");
      wr(ADR_CTRL, 8'h01);
      for (int i = 0; i < 4; i++) rd(4'(i), rank_aux[i], "rank aux");
      wr(ADR_CTRL, 8'h00);
      rd(4'hF, 8'h00, "unmapped");
      done("reset");
      run_to(8'hFF);
      cm(4'h2);
      ca(4'h2);
      rd(ADR_TAB_A, 8'h22, "table a");
      rd(ADR_TAB_B, 8'h43, "table b");
      rd(ADR_VALID, 8'hFF, "valid");
      wr(ADR_LATCH1, 8'hFF);
      wr(ADR_IEN1, 8'h02);
      run_to(8'hFD);
      cm(4'h3);
      ca(4'h3);
      run_to(8'hFF);
      cm(4'h3);
      ca(4'h2);
      rd(ADR_TAB_A, 8'h23, "table a");
      rd(ADR_LATCH1, 8'h02, "latched");
      chk("irq", 8'h01, {7'h0, interrupt_request_pin_o});
      wr(ADR_LATCH1, 8'h02);
      cyc(2);
      chk("irq", 8'h00, {7'h0, interrupt_request_pin_o});
      done("auto");
      wr(ADR_CTRL, 8'h02);
      wr(ADR_CTRL, 8'h00);
      cyc(2);
      cm(4'h2);
      wr(ADR_CTRL, 8'h02);
      run_to(8'hFD);
      run_to(8'hFF);
      cm(4'h2);
      wr(ADR_RANK1, 8'h11);
      run_to(8'hFD);
      cm(4'h3);
      run_to(8'hFF);
      cm(4'h3);
      run_to(8'hFB);
      cm(4'h4);
      run_to(8'hFF);
      cm(4'h4);
      wr(ADR_RANK1, 8'h32);
      wr(ADR_CTRL, 8'h04);
      cyc(2);
      cm(4'h2);
      done("revertive_switch_en");
      @(posedge mclk_i) gap <= 1'b1;
      @(posedge mclk_i) gap <= 1'b0;
      cyc(4);
      cm(4'h3);
      rd(ADR_LATCH2, 8'h01, "fail flag");
      wr(ADR_LATCH2, 8'h01);
      rd(ADR_LATCH2, 8'h00, "fail clear");
      run_to(8'hFD);
      run_to(8'hFF);
      wr(ADR_CTRL, 8'h10);
      wr(ADR_AUX_FORCE, 8'h04);
      cyc(2);
      ca(4'h4);
      wr(ADR_AUX_FORCE, 8'h00);
      done("ufs");
      wr(ADR_CTRL, 8'h02);
      wr(ADR_RANK0, 8'h1F);
      wr(ADR_RANK2, 8'hEE);
      for (int c = 0; c < 16; c++) begin
         wr(ADR_MAIN_FORCE, 8'(c));
         cyc(2);
         exp_sel = (c == 0 || c == 15) ? 4'h2 : ((c == 7 || c > 9) ? NO_REF : 4'(c));
         cm(exp_sel);
         if (c == 1 || (c > 4 && c < 10 && c != 7)) begin
            rd(ADR_TAB_A, {4'(c), 4'(c)}, "table a");
            rd(ADR_TAB_B, 8'h32, "table b");
         end
      end
      wr(ADR_MAIN_FORCE, 8'h00);
      wr(ADR_CTRL, 8'h00);
      wr(ADR_MAIN_FORCE, 8'h08);
      cyc(2);
      cm(4'h2);
      rd(ADR_TAB_A, 8'h82, "table a");
      run_to(8'hFD);
      cm(4'h8);
      run_to(8'hFF);
      wr(ADR_MAIN_FORCE, 8'h00);
      done("force");
      wr(ADR_CTRL, 8'h08);
      pin_to(1'b1);
      cm(4'h3);
      run_to(8'hFB);
      cm(4'h3);
      rd(ADR_TAB_A, 8'h23, "table a");
      pin_to(1'b0);
      cm(4'h4);
      wr(ADR_RANK1, 8'h00);
      cyc(2);
      cm(4'h6);
      pin_to(1'b1);
      cm(4'h5);
      @(posedge mclk_i) rst_i <= 1'b1;
      @(posedge mclk_i) rst_i <= 1'b0;
      cyc(2);
      chk("tol wide", 8'h01, {7'h0, freq_tol_wide_o});
      rd(ADR_CTRL, 8'h08, "ctrl");
      rd(ADR_TOL, 8'h01, "tolerance");
      wr(ADR_TOL, 8'h00);
      rd(ADR_TOL, 8'h00, "tolerance");
      cm(4'h3);
      done("external");
      @(posedge mclk_i) ce_i <= 1'b0;
      run_to(8'hFD);
      ca(4'h2);
      @(posedge mclk_i) ce_i <= 1'b1;
      cyc(2);
      ca(4'h3);
      done("enable");
      print_verdict();
   end
endmodule
